// >>> rsc_pkg.sv
// constants and types shared by the strap capture block
package rsc_pkg;
  // pin group widths
  localparam int unsigned STRAP_W      = 8;
  localparam int unsigned PLAT_RATIO_W = 4;
  localparam int unsigned CORE_RATIO_W = 5;

  // pulled-up straps read high when nothing drives them: all ones is the default setting
  localparam logic [STRAP_W-1:0]      STRAP_RESET_VALUE = 8'hff;
  // ratio straps have no pull-up, so their reset value carries no meaning
  localparam logic [PLAT_RATIO_W-1:0] PLAT_RATIO_RESET  = 4'h0;
  localparam logic [CORE_RATIO_W-1:0] CORE_RATIO_RESET  = 5'h00;

  // pull-up and receiver stay on for this many clock cycles after the release
  localparam int unsigned      PULLUP_HOLD_CYCLES = 4;
  localparam logic [3:0]       PULLUP_HOLD_LAST   = 4'(PULLUP_HOLD_CYCLES - 1);
  localparam logic [3:0]       HOLD_CNT_RESET     = 4'h0;

  // tck rising edges with tms high that force the tap into its reset state
  localparam int unsigned      TAP_RESET_EDGES = 5;
  localparam logic [2:0]       TAP_RESET_LAST  = 3'(TAP_RESET_EDGES);
  localparam logic [2:0]       TAP_CNT_RESET   = 3'h0;

  // capture sequencer states, one-hot
  typedef enum logic [2:0] {
    RSC_ST_RESET = 3'h1,  // hard reset held: pins are inputs
    RSC_ST_HOLD  = 3'h2,  // released: value latched, pull-up kept a few cycles
    RSC_ST_RUN   = 3'h4   // pins back on output duty
  } rsc_state_t;
endpackage : rsc_pkg

// >>> rsc_tap_if.sv
// signals between the strap capture top and its tap reset monitor
`timescale 1ns/100ps
`default_nettype none
interface rsc_tap_if;
  logic tck;
  logic tms;
  logic trst_n;
  logic tap_reset;

  modport top (output tck, output tms, output trst_n, input  tap_reset);
  modport mon (input  tck, input  tms, input  trst_n, output tap_reset);
endinterface : rsc_tap_if
`default_nettype wire

// >>> rsc_tap_monitor.sv
// tracks whether the test port controller sits in its reset state
`timescale 1ns/100ps
`default_nettype none
module rsc_tap_monitor (
  input  wire logic clock,
  input  wire logic resetn,
  rsc_tap_if.mon    tap
);
  logic       tck_prev;
  logic       next_tck_prev;
  logic [2:0] tms_count;
  logic [2:0] next_tms_count;
  logic       in_reset;
  logic       next_in_reset;
  logic       tck_rise;

  // tck is sampled as a plain synchronous input, so a delayed copy finds its edge
  always_comb begin
    tck_rise       = tap.tck & ~tck_prev;
    next_tck_prev  = tap.tck;
    next_tms_count = tms_count;
    next_in_reset  = in_reset;
    if (!tap.trst_n) begin
      next_tms_count = TAP_CNT_RESET_F;
      next_in_reset  = 1'b1;
    end else if (tck_rise) begin
      if (tap.tms) begin
        if (tms_count != rsc_pkg::TAP_RESET_LAST) begin
          next_tms_count = tms_count + 3'h1;
        end
        if (tms_count == rsc_pkg::TAP_RESET_LAST - 3'h1) begin
          next_in_reset = 1'b1;
        end
      end else begin
        // tms low leaves test-logic-reset for run-test-idle
        next_tms_count = rsc_pkg::TAP_CNT_RESET;
        next_in_reset  = 1'b0;
      end
    end
  end

  localparam logic [2:0] TAP_CNT_RESET_F = rsc_pkg::TAP_CNT_RESET;

  // the controller powers up in reset until told otherwise
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      tck_prev  <= 1'b0;
      tms_count <= rsc_pkg::TAP_CNT_RESET;
      in_reset  <= 1'b1;
    end else begin
      tck_prev  <= next_tck_prev;
      tms_count <= next_tms_count;
      in_reset  <= next_in_reset;
    end
  end

  assign tap.tap_reset = in_reset;
endmodule : rsc_tap_monitor
`default_nettype wire

// >>> rsc_strap_capture.sv
// power-on strap capture and test port reset tracking
//
// Summary of operation
// - While hard reset is held, every strap pin is an input.
// - On hard reset release, latch straps; with the pull-up, drop the receiver and resume output duty.
// - Gated pull-up is on during hard reset and a few cycles after release.
// - Pull-up is off whenever the pin's receiver is off.
// - A sampled high strap bit selects the default; low selects the alternative.
// - Ratio straps have no pull-up; their value is whatever the board drives.
// - Tap reset comes from test reset, from async reset or from tck and tms alone.
`timescale 1ns/100ps
`default_nettype none
module rsc_strap_capture (
  input  wire logic                             clock,
  input  wire logic                             resetn,
  input  wire logic                             hard_reset_in_n,
  input  wire logic [rsc_pkg::STRAP_W-1:0]      strap_pin_in,
  output var  logic [rsc_pkg::STRAP_W-1:0]      strap_pin_out,
  output var  logic [rsc_pkg::STRAP_W-1:0]      strap_pin_oe_n,
  output var  logic [rsc_pkg::STRAP_W-1:0]      strap_pullup_en,
  output var  logic [rsc_pkg::STRAP_W-1:0]      strap_rx_en,
  input  wire logic [rsc_pkg::STRAP_W-1:0]      func_out,
  input  wire logic [rsc_pkg::PLAT_RATIO_W-1:0] plat_ratio_in,
  input  wire logic [rsc_pkg::CORE_RATIO_W-1:0] core_ratio_in,
  output var  logic [rsc_pkg::STRAP_W-1:0]      strap_value,
  output var  logic [rsc_pkg::PLAT_RATIO_W-1:0] plat_ratio,
  output var  logic [rsc_pkg::CORE_RATIO_W-1:0] core_ratio,
  output var  logic                             config_valid,
  input  wire logic                             tck,
  input  wire logic                             tms,
  input  wire logic                             trst_n,
  output var  logic                             tap_reset
);
  rsc_pkg::rsc_state_t                 state;
  rsc_pkg::rsc_state_t                 next_state;
  logic [3:0]                          hold_cnt;
  logic [3:0]                          next_hold_cnt;
  logic [rsc_pkg::STRAP_W-1:0]         next_strap_value;
  logic [rsc_pkg::PLAT_RATIO_W-1:0]    next_plat_ratio;
  logic [rsc_pkg::CORE_RATIO_W-1:0]    next_core_ratio;
  logic                                next_config_valid;
  logic                                next_pins_input;
  logic                                next_pull_on;
  logic [rsc_pkg::STRAP_W-1:0]         next_pin_out;
  logic                                pins_input;
  logic                                pull_on;

  rsc_tap_if tap_bus ();

  // the monitor works from test reset and the tck/tms pair; the board keeps
  // test reset apart from hard reset, so the two are never merged here
  assign tap_bus.tck    = tck;
  assign tap_bus.tms    = tms;
  assign tap_bus.trst_n = trst_n;

  rsc_tap_monitor u_tap_monitor (
    .clock  (clock),
    .resetn (resetn),
    .tap    (tap_bus.mon)
  );

  // tap reset is already a flop inside the monitor
  assign tap_reset = tap_bus.tap_reset;

  // capture sequencer: hard reset can return from any state at any time
  always_comb begin
    next_state        = state;
    next_hold_cnt     = hold_cnt;
    next_strap_value  = strap_value;
    next_plat_ratio   = plat_ratio;
    next_core_ratio   = core_ratio;
    next_config_valid = config_valid;
    next_pins_input   = 1'b1;
    next_pull_on      = 1'b1;
    next_pin_out      = func_out;
    if (!hard_reset_in_n) begin
      // a probe or board reset may land here at any time; pins turn around
      next_state        = rsc_pkg::RSC_ST_RESET;
      next_hold_cnt     = rsc_pkg::HOLD_CNT_RESET;
      next_config_valid = 1'b0;
      next_pins_input   = 1'b1;
      next_pull_on      = 1'b1;
    end else begin
      case (state)
        rsc_pkg::RSC_ST_RESET: begin
          // first cycle with reset released: take the level the pins present
          next_strap_value  = strap_pin_in;
          next_plat_ratio   = plat_ratio_in;
          next_core_ratio   = core_ratio_in;
          next_config_valid = 1'b1;
          next_hold_cnt     = rsc_pkg::HOLD_CNT_RESET;
          next_state        = rsc_pkg::RSC_ST_HOLD;
          next_pins_input   = 1'b1;
          next_pull_on      = 1'b1;
        end
        rsc_pkg::RSC_ST_HOLD: begin
          // pull-up lingers so a slow pin settles; outputs stay off meanwhile
          next_pins_input = 1'b1;
          next_pull_on    = 1'b1;
          if (hold_cnt == rsc_pkg::PULLUP_HOLD_LAST) begin
            next_state      = rsc_pkg::RSC_ST_RUN;
            next_pins_input = 1'b0;
            next_pull_on    = 1'b0;
          end else begin
            next_hold_cnt = hold_cnt + 4'h1;
          end
        end
        rsc_pkg::RSC_ST_RUN: begin
          // latched values left alone; pin activity now is output traffic
          next_pins_input = 1'b0;
          next_pull_on    = 1'b0;
        end
        default: begin
          next_state = rsc_pkg::RSC_ST_RESET;
        end
      endcase
    end
  end

  // async reset puts the block where hard reset would: pins as inputs, pulled up
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state         <= rsc_pkg::RSC_ST_RESET;
      hold_cnt      <= rsc_pkg::HOLD_CNT_RESET;
      strap_value   <= rsc_pkg::STRAP_RESET_VALUE;
      plat_ratio    <= rsc_pkg::PLAT_RATIO_RESET;
      core_ratio    <= rsc_pkg::CORE_RATIO_RESET;
      config_valid  <= 1'b0;
      pins_input    <= 1'b1;
      pull_on       <= 1'b1;
      strap_pin_out <= '0;
    end else begin
      state         <= next_state;
      hold_cnt      <= next_hold_cnt;
      strap_value   <= next_strap_value;
      plat_ratio    <= next_plat_ratio;
      core_ratio    <= next_core_ratio;
      config_valid  <= next_config_valid;
      pins_input    <= next_pins_input;
      pull_on       <= next_pull_on;
      strap_pin_out <= next_pin_out;
    end
  end

  // per-pin controls are registered copies; oe and receiver leave a flop, pull-up an AND of two flops;
  // pull-up is gated by the receiver flop, so it is never on while the receiver is off
  always_comb begin
    strap_pin_oe_n  = {rsc_pkg::STRAP_W{pins_input}};
    strap_rx_en     = {rsc_pkg::STRAP_W{pins_input}};
    strap_pullup_en = {rsc_pkg::STRAP_W{pull_on & pins_input}};
  end
endmodule : rsc_strap_capture
`default_nettype wire

// >>> rsc_strap_capture_chk.sv
// concurrent checks on the strap capture top ports
`timescale 1ns/100ps
`default_nettype none
module rsc_strap_capture_chk (
  input wire logic       clock,
  input wire logic       resetn,
  input wire logic       hard_reset_in_n,
  input wire logic [7:0] strap_pin_in,
  input wire logic [7:0] strap_pin_oe_n,
  input wire logic [7:0] strap_pullup_en,
  input wire logic [7:0] strap_rx_en,
  input wire logic [7:0] strap_value,
  input wire logic       config_valid,
  input wire logic       tck,
  input wire logic       tms,
  input wire logic       trst_n,
  input wire logic       tap_reset
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  // hard reset held: pins stay inputs and the old config is withdrawn
  property p_in_rst; !hard_reset_in_n |=> &strap_pin_oe_n && &strap_pullup_en && !config_valid;
  endproperty
  a_in_rst: assert property (p_in_rst) else $error("pins not inputs");
  property p_cap; !hard_reset_in_n ##1 hard_reset_in_n |=>
    config_valid && strap_value == $past(strap_pin_in); endproperty
  a_cap: assert property (p_cap) else $error("strap not latched");
  // pull-up must outlive the latch edge by the hold count, then all drop together
  property p_keep; !hard_reset_in_n ##1 hard_reset_in_n [*4] |=> &strap_pullup_en; endproperty
  a_keep: assert property (p_keep) else $error("pull-up dropped early");
  property p_drop; !hard_reset_in_n ##1 hard_reset_in_n [*5] |=>
    strap_pin_oe_n == 8'h00 && strap_rx_en == 8'h00 && strap_pullup_en == 8'h00; endproperty
  a_drop: assert property (p_drop) else $error("pins not released");
  property p_pu; (strap_pullup_en & ~strap_rx_en) == 8'h00; endproperty
  a_pu: assert property (p_pu) else $error("pull-up without receiver");
  property p_held; config_valid && hard_reset_in_n |=> config_valid && $stable(strap_value);
  endproperty
  a_held: assert property (p_held) else $error("latched value moved");
  // tap reset tracking
  property p_trst; !trst_n |=> tap_reset; endproperty
  a_trst: assert property (p_trst) else $error("tap not reset");
  property p_clr; $rose(tck) && !tms && trst_n |=> !tap_reset; endproperty
  a_clr: assert property (p_clr) else $error("tap reset stuck");
  c_cap: cover property (!hard_reset_in_n ##1 hard_reset_in_n [*6]);
  c_tap: cover property ($rose(tap_reset));
  c_abort: cover property (config_valid ##1 !hard_reset_in_n);
endmodule : rsc_strap_capture_chk
bind rsc_strap_capture rsc_strap_capture_chk u_chk (.clock(clock), .resetn(resetn),
  .hard_reset_in_n(hard_reset_in_n), .strap_pin_in(strap_pin_in), .tck(tck), .tms(tms),
  .strap_pin_oe_n(strap_pin_oe_n), .strap_pullup_en(strap_pullup_en), .trst_n(trst_n),
  .strap_rx_en(strap_rx_en), .strap_value(strap_value), .config_valid(config_valid),
  .tap_reset(tap_reset));
`default_nettype wire

// >>> rsc_board_model.sv
// board straps, reset merge and debug probe as seen from the pins
`timescale 1ns/100ps
`default_nettype none
module rsc_board_model (
  input  wire logic       clock,
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] oe_n,
  input  wire logic [7:0] pu_en,
  input  wire logic [7:0] pull_down,
  input  wire logic       board_rst_n,
  input  wire logic       probe_hrst_n,
  input  wire logic       probe_trst_n,
  output var  logic [7:0] pin_in,
  output var  logic       hard_reset_in_n,
  output var  logic       trst_n
);
  logic [7:0] wander = 8'h5a;
  // a floating pin toggles so a stale level is never read by luck
  always_ff @(posedge clock) wander <= ~wander;
  // driver beats the pull-down, pull-down beats the weak pull-up
  assign pin_in = ~oe_n & pin_out | oe_n & ~pull_down & (pu_en | wander);
  // either source pulls hard reset; test reset never follows it
  assign hard_reset_in_n = board_rst_n & probe_hrst_n;
  assign trst_n          = probe_trst_n;
endmodule : rsc_board_model
`default_nettype wire

// >>> rsc_strap_capture_tb_top.sv
// self-checking bench for strap capture and tap reset tracking
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin bad_count++; \
  $display("ERROR %0t %h %h", $time, a, b); end end
module rsc_strap_capture_tb_top;
  logic       clock = 1'b0, resetn = 1'b0, tck = 1'b0, tms = 1'b0;
  logic       board_rst_n = 1'b0, probe_hrst_n = 1'b1, probe_trst_n = 1'b0;
  logic [7:0] pull_down = 8'h00, func_out = 8'h00;
  logic [3:0] plat_in = 4'h0;
  logic [4:0] core_in = 5'h00;
  wire  logic       hrst_n, trst_n, cfg_ok, tap_reset;
  wire  logic [7:0] pin_in, pin_out, oe_n, pu_en, rx_en, strap_value;
  wire  logic [3:0] plat_ratio;
  wire  logic [4:0] core_ratio;
  int         bad_count = 0, n_tests = 0, seed = 59417, exp_q[$];
  rsc_board_model u_board (.clock(clock), .pin_out(pin_out), .oe_n(oe_n), .pu_en(pu_en),
    .pull_down(pull_down), .board_rst_n(board_rst_n), .probe_hrst_n(probe_hrst_n),
    .probe_trst_n(probe_trst_n), .pin_in(pin_in), .hard_reset_in_n(hrst_n), .trst_n(trst_n));
  rsc_strap_capture u_dut (.clock(clock), .resetn(resetn), .hard_reset_in_n(hrst_n),
    .strap_pin_in(pin_in), .strap_pin_out(pin_out), .strap_pin_oe_n(oe_n),
    .strap_pullup_en(pu_en), .strap_rx_en(rx_en), .func_out(func_out), .plat_ratio_in(plat_in),
    .core_ratio_in(core_in), .strap_value(strap_value), .plat_ratio(plat_ratio),
    .core_ratio(core_ratio), .config_valid(cfg_ok), .tck(tck), .tms(tms), .trst_n(trst_n),
    .tap_reset(tap_reset));
  initial forever #4 clock = ~clock;
  task automatic print_verdict();
    if (bad_count == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : cyc
  // tck held two cycles per level, as the tap tracker needs
  task automatic tck_rise(input logic m);
    @(posedge clock) begin tms <= m; tck <= 1'b1; end
    repeat (2) @(posedge clock);
    tck <= 1'b0;
    cyc(2);
  endtask : tck_rise
  initial begin #100000; bad_count++; print_verdict(); end
  initial begin
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    // odd rounds use the probe, even rounds the board source
    for (int it = 0; it < 8; it++) begin
      @(posedge clock) begin
        if (it[0]) probe_hrst_n <= 1'b0; else board_rst_n <= 1'b0;
        pull_down <= 8'($random(seed)); plat_in <= 4'($random(seed));
        core_in <= 5'($random(seed));
      end
      cyc(2);
      exp_q = {int'(~pull_down), int'(plat_in), int'(core_in)};
      `CHK({oe_n, pu_en, rx_en, cfg_ok}, 25'h1fffffe)
      @(posedge clock) begin board_rst_n <= 1'b1; probe_hrst_n <= 1'b1; end
      cyc(1);
      `CHK({strap_value, plat_ratio, core_ratio}, 17'(exp_q[0] << 9 | exp_q[1] << 5 | exp_q[2]))
      cyc(3);
      `CHK(pu_en & rx_en & oe_n, 8'hff)
      cyc(1);
      `CHK({oe_n, rx_en, pu_en}, 24'h0)
      @(posedge clock) begin pull_down <= ~pull_down; plat_in <= ~plat_in; end
      @(posedge clock) func_out <= 8'($random(seed));
      cyc(2);
      `CHK({strap_value, plat_ratio, cfg_ok}, 13'(exp_q[0] << 5 | exp_q[1] << 1 | 1))
      `CHK(pin_out, func_out)
    end
    `CHK(tap_reset, 1'b1)
    @(posedge clock) probe_trst_n <= 1'b1;
    tck_rise(1'b0);
    `CHK(tap_reset, 1'b0)
    for (int k = 1; k <= rsc_pkg::TAP_RESET_EDGES; k++) begin
      tck_rise(1'b1);
      `CHK(tap_reset, k == rsc_pkg::TAP_RESET_EDGES)
    end
    print_verdict();
  end
endmodule : rsc_strap_capture_tb_top
`default_nettype wire
